//--- rtl/spi_pin_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - Separate pins: master reads miso, slave drives.
// - Single-wire slave: one pin, direction from enable.
// - Single-wire master releases miso to ordinary I/O.
// - Slave: select pin is active-low input.
// - Master without fault function ignores select pin.
// - Master with fault: select-out bit picks role.
// - Any stop mode disables the serial port.
// - Deep power down returns module to reset.
// - Clock halt freezes state, resumes when the halt input drops.
// - Five eight-bit software registers.
// - Bit 7 gates receive-full and fault interrupt.
// - Disable aborts transfer, empties buffers, resets flags.
// - Bit 5 gates transmit-empty interrupt.
// - Bit 4 selects slave or master.
// - Bit 3 inverts clock, sets idle level.
// - Bit 2 places first clock edge.
// - Bit 0 selects least-significant bit first.
// - Disabled port leaves all four pins alone.
// - Shared-pin enable matters only in single-wire.
module spi_pin_ctrl
  import spi_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic deep_power_down,
  input wire logic clock_halt_stop,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic select_n_in,
  output logic select_n_out,
  output logic select_n_oe,
  output logic irq
);

  pin_sync_if sync ();

  pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins({miso_in, mosi_in, select_n_in, serial_clock_pin_in}),
    .sync(sync.producer)
  );

  logic [7:0] ctrl1_q, ctrl2_q, baud_q, tx_buf_q, rx_buf_q, shreg_q;
  logic tx_empty_q, rx_full_q, mode_fault_flag_q, sbit_q, sclk_state_q;
  logic [2:0] bitcnt_q;
  logic [4:0] step_q;
  logic [10:0] div_q;
  xfer_state_t st_q;
  logic wr_pend_q, rd_pend_q, hreadyout_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;

  logic run, active, master, clock_phase, clock_polarity, lsbf, single_wire, shared_oe, mode_fault_en, sel_out_en;
  logic addr_ph, wr_en, rd_data_evt, fault_now, start_m, start_s, abort;
  logic [10:0] half_lim;
  logic tick;
  logic [5:0] jstep;
  logic m_edge, sample_evt, shift_evt, done_evt, din, dout;
  logic [7:0] rd_byte, rx_byte;

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // A halted clock freezes everything but the pin synchroniser, the pin drivers, the bus handshake and the irq flop; the pins must still let go.
  assign run = ~clock_halt_stop;
  assign active = ctrl1_q[C1_SYSTEM_EN] & ~deep_power_down & ~clock_halt_stop;
  assign master = ctrl1_q[C1_MASTER];
  assign clock_phase = ctrl1_q[C1_PHASE];
  assign clock_polarity = ctrl1_q[C1_POLARITY];
  assign lsbf = ctrl1_q[C1_LOW_BIT_FIRST];
  assign single_wire = ctrl2_q[C2_SINGLE_WIRE];
  assign shared_oe = ctrl2_q[C2_SHARED_OE];
  assign mode_fault_en = ctrl2_q[C2_MODE_FAULT_EN];
  assign sel_out_en = ctrl1_q[C1_SELECT_OUT_EN];

  // Bus decode: writes land in the data phase, reads take one wait state.
  assign addr_ph = hsel & hready & htrans[1];
  assign wr_en = wr_pend_q & run;
  assign rd_data_evt = rd_pend_q & run & (addr_q == ADDR_DATA);
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Five byte-wide registers; the rest of the window reads zero.
  always_comb begin
    unique case (addr_q)
      ADDR_CTRL1: rd_byte = ctrl1_q;
      ADDR_CTRL2: rd_byte = ctrl2_q & CTRL2_MASK;
      ADDR_BAUD: rd_byte = baud_q & BAUD_MASK;
      ADDR_STATUS: rd_byte = {rx_full_q, 1'b0, tx_empty_q, mode_fault_flag_q, 4'h0};
      ADDR_DATA: rd_byte = rx_buf_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus handshake state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      rd_pend_q <= addr_ph & ~hwrite;
      hreadyout_q <= ~(addr_ph & ~hwrite);
      if (addr_ph) begin
        addr_q <= haddr[7:0];
      end
      if (rd_pend_q) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // A master seeing its select input pulled low has a bus conflict.
  assign fault_now = active & master & mode_fault_en & ~sel_out_en & ~sync.sel_n_lvl;

  // Control registers; a deep power down wipes them back to reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_q <= CTRL1_RESET;
      ctrl2_q <= CTRL2_RESET;
      baud_q <= BAUD_RESET;
    end else if (deep_power_down) begin
      ctrl1_q <= CTRL1_RESET;
      ctrl2_q <= CTRL2_RESET;
      baud_q <= BAUD_RESET;
    end else if (run) begin
      if (wr_en && addr_q == ADDR_CTRL1) begin
        ctrl1_q <= hwdata[7:0];
      end
      if (wr_en && addr_q == ADDR_CTRL2) begin
        ctrl2_q <= hwdata[7:0] & CTRL2_MASK;
      end
      if (wr_en && addr_q == ADDR_BAUD) begin
        baud_q <= hwdata[7:0] & BAUD_MASK;
      end
      if (fault_now) begin
        ctrl1_q[C1_MASTER] <= 1'b0;  // Fault drops back to slave.
      end
    end
  end

  // Half bit period in bus cycles is the prescale field plus one, times two to the rate field.
  assign half_lim = 11'(({8'h00, baud_q[B_PRESCALE_LSB +: 3]} + 11'h001)
                        << baud_q[B_RATE_LSB +: 3]) - 11'h001;
  assign tick = (div_q == half_lim);

  // Step plus phase lines both formats up: edges at 1..16, leading on odd.
  assign jstep = {1'b0, step_q} + {5'h00, clock_phase};
  assign m_edge = (jstep >= 6'h01) && (jstep <= 6'h10);
  assign start_m = active & master & ~tx_empty_q & (st_q == XF_IDLE) & ~fault_now;
  assign start_s = active & ~master & (st_q == XF_IDLE) & sync.sel_n_fall;
  assign abort = ~ctrl1_q[C1_SYSTEM_EN] | (st_q == XF_MASTER && fault_now)
               | (st_q == XF_SLAVE && sync.sel_n_lvl);

  // Sample and shift moments from the own clock as master or the pin as slave.
  always_comb begin
    sample_evt = 1'b0;
    shift_evt = 1'b0;
    if (st_q == XF_MASTER && tick) begin
      sample_evt = m_edge && (jstep[0] != clock_phase);
      shift_evt = (jstep[0] == clock_phase) && (jstep >= 6'h02);
    end else if (st_q == XF_SLAVE) begin
      // Polarity swaps which physical edge leads.
      sample_evt = clock_phase ? (clock_polarity ? sync.sclk_rise : sync.sclk_fall)
                        : (clock_polarity ? sync.sclk_fall : sync.sclk_rise);
      shift_evt = clock_phase ? (clock_polarity ? sync.sclk_fall : sync.sclk_rise)
                       : (clock_polarity ? sync.sclk_rise : sync.sclk_fall);
    end
    shift_evt = shift_evt & (bitcnt_q != 3'h0);
  end

  // Data-in follows role and wiring; the shared wire is the only choice in single-wire.
  // Reading the synchronised level keeps din two flops behind the pin.
  assign din = master ? (single_wire ? sync.mosi_lvl : sync.miso_lvl)
                      : (single_wire ? sync.miso_lvl : sync.mosi_lvl);
  assign dout = lsbf ? shreg_q[0] : shreg_q[7];
  assign done_evt = sample_evt && (bitcnt_q == LAST_BIT);
  assign rx_byte = shift_in(shreg_q, din, lsbf);

  // Transfer engine; disabling or a deep power down aborts, a halt only freezes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= XF_IDLE;
      shreg_q <= 8'h00;
      sbit_q <= 1'b0;
      bitcnt_q <= 3'h0;
      step_q <= 5'h00;
      div_q <= 11'h000;
      sclk_state_q <= 1'b0;
    end else if (deep_power_down) begin
      st_q <= XF_IDLE;
      shreg_q <= 8'h00;
      bitcnt_q <= 3'h0;
      sclk_state_q <= 1'b0;
    end else if (run) begin
      if (abort) begin
        st_q <= XF_IDLE;
        bitcnt_q <= 3'h0;
        sclk_state_q <= 1'b0;
      end else if (start_m || start_s) begin
        st_q <= start_m ? XF_MASTER : XF_SLAVE;
        shreg_q <= tx_buf_q;
        bitcnt_q <= 3'h0;
        step_q <= 5'h00;
        div_q <= 11'h000;
        sclk_state_q <= 1'b0;
      end else if (st_q != XF_IDLE) begin
        if (st_q == XF_MASTER) begin
          div_q <= tick ? 11'h000 : div_q + 11'h001;
          if (tick) begin
            step_q <= step_q + 5'h01;
            if (m_edge) begin
              sclk_state_q <= ~sclk_state_q;
            end
            if (step_q == HALF_STEPS) begin
              st_q <= XF_IDLE;
            end
          end
        end
        if (done_evt) begin
          bitcnt_q <= 3'h0;
          if (st_q == XF_SLAVE) begin
            st_q <= XF_IDLE;
          end
        end else if (sample_evt) begin
          sbit_q <= din;
          bitcnt_q <= bitcnt_q + 3'h1;
        end
        if (shift_evt && !done_evt) begin
          shreg_q <= shift_in(shreg_q, sbit_q, lsbf);
        end
      end
    end
  end

  // Buffers and flags; receive-full and mode-fault sets win over software clears, a data write wins over a start.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_q <= 8'h00;
      rx_buf_q <= 8'h00;
      tx_empty_q <= 1'b1;
      rx_full_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
    end else if (deep_power_down) begin
      tx_buf_q <= 8'h00;
      rx_buf_q <= 8'h00;
      tx_empty_q <= 1'b1;
      rx_full_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
    end else if (run) begin
      if (!ctrl1_q[C1_SYSTEM_EN]) begin
        tx_buf_q <= 8'h00;
        rx_buf_q <= 8'h00;
        tx_empty_q <= 1'b1;
        rx_full_q <= 1'b0;
      end else begin
        if (wr_en && addr_q == ADDR_DATA && tx_empty_q) begin
          tx_buf_q <= hwdata[7:0];
          tx_empty_q <= 1'b0;
        end else if (start_m || start_s) begin
          tx_empty_q <= 1'b1;
        end
        if (done_evt) begin
          rx_buf_q <= rx_byte;
          rx_full_q <= 1'b1;
        end else if (rd_data_evt) begin
          rx_full_q <= 1'b0;
        end
      end
      if (fault_now) begin
        mode_fault_flag_q <= 1'b1;
      end else if (wr_en && addr_q == ADDR_CTRL1) begin
        mode_fault_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt request is a plain level of the enabled flags.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (ctrl1_q[C1_RX_FAULT_IRQ_EN] & (rx_full_q | mode_fault_flag_q))
           | (ctrl1_q[C1_TX_EMPTY_IRQ_EN] & tx_empty_q);
    end
  end

  // Pin routing, registered so every pin comes from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      select_n_out <= 1'b1;
      select_n_oe <= 1'b0;
    end else begin
      serial_clock_pin_out <= sclk_state_q ^ clock_polarity;
      serial_clock_pin_oe <= active & master;
      mosi_out <= dout;
      miso_out <= dout;
      // Single-wire master uses mosi, single-wire slave uses miso.
      mosi_oe <= active & master & (~single_wire | shared_oe);
      miso_oe <= active & ~master
               & (single_wire ? shared_oe : ~sync.sel_n_lvl);
      select_n_out <= ~(st_q == XF_MASTER);
      select_n_oe <= active & master & mode_fault_en & sel_out_en;
    end
  end

  AST_DISABLED_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    !active |=> !(serial_clock_pin_oe | mosi_oe | miso_oe | select_n_oe))
    else $error("Pins still driven while the port is off.");

  AST_STOP_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
    (deep_power_down || clock_halt_stop) |=> !(serial_clock_pin_oe | mosi_oe | miso_oe))
    else $error("Pins driven during a stop mode.");

  AST_SLAVE_SELECT_IN: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && !master) |=> !select_n_oe && !serial_clock_pin_oe)
    else $error("Slave drives select or clock.");

  AST_MASTER_NO_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && master && !mode_fault_en) |=> !select_n_oe)
    else $error("Master uses select pin with fault function off.");

  AST_SELECT_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && master && mode_fault_en) |=> select_n_oe == $past(sel_out_en))
    else $error("Select pin role disagrees with select-out bit.");

  AST_SLAVE_SHARED: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && !master && single_wire) |=> miso_oe == $past(shared_oe) && !mosi_oe)
    else $error("Single-wire slave pin direction wrong.");

  AST_MASTER_SHARED: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && master && single_wire) |=> !miso_oe && mosi_oe == $past(shared_oe))
    else $error("Single-wire master touches the wrong pin.");

  AST_DISABLE_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn)
    ($fell(ctrl1_q[C1_SYSTEM_EN]) && run && !deep_power_down)
      |=> tx_empty_q && !rx_full_q && st_q == XF_IDLE)
    else $error("Disable did not reset flags and engine.");

  AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl1_q[C1_TX_EMPTY_IRQ_EN] && tx_empty_q) ##1 $stable(ctrl1_q) |-> irq)
    else $error("Enabled empty flag raised no request.");

  AST_HALT_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
    (clock_halt_stop && !deep_power_down) |=> $stable(ctrl1_q) && $stable(st_q))
    else $error("State moved while clocks halted.");

  AST_DEEP_WIPES: assert property (@(posedge hclk) disable iff (!hresetn)
    deep_power_down |=> ctrl1_q == CTRL1_RESET && st_q == XF_IDLE)
    else $error("Deep power down left state behind.");

  AST_IDLE_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && master && st_q == XF_IDLE) ##1 $stable(ctrl1_q) |-> serial_clock_pin_out == clock_polarity)
    else $error("Idle master clock not at polarity level.");

  COV_MASTER_BYTE: cover property (@(posedge hclk) st_q == XF_MASTER && done_evt);
  COV_SLAVE_BYTE: cover property (@(posedge hclk) st_q == XF_SLAVE && done_evt);
  COV_MODE_FAULT: cover property (@(posedge hclk) fault_now);

endmodule

//--- rtl/spi_cfg_pkg.sv
package spi_cfg_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // Field positions in serial_port_control_one.
  localparam int C1_RX_FAULT_IRQ_EN = 7;
  localparam int C1_SYSTEM_EN = 6;
  localparam int C1_TX_EMPTY_IRQ_EN = 5;
  localparam int C1_MASTER = 4;
  localparam int C1_POLARITY = 3;
  localparam int C1_PHASE = 2;
  localparam int C1_SELECT_OUT_EN = 1;
  localparam int C1_LOW_BIT_FIRST = 0;

  // Field positions in the second control register.
  localparam int C2_MODE_FAULT_EN = 4;
  localparam int C2_SHARED_OE = 3;
  localparam int C2_SINGLE_WIRE = 0;

  // Field positions in the status and baud registers.
  localparam int S_RX_FULL = 7;
  localparam int S_TX_EMPTY = 5;
  localparam int S_MODE_FAULT = 4;
  localparam int B_PRESCALE_LSB = 4;
  localparam int B_RATE_LSB = 0;

  // Reset values and writable-bit masks.
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] CTRL2_MASK = 8'h1B;
  localparam logic [7:0] BAUD_MASK = 8'h77;

  // Pin indices into the synchroniser.
  localparam int PIN_SCLK = 0;
  localparam int PIN_SEL_N = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;
  localparam int PIN_COUNT = 4;

  // Byte framing: sixteen half bit periods, eight samples.
  localparam logic [4:0] HALF_STEPS = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {XF_IDLE, XF_MASTER, XF_SLAVE} xfer_state_t;

endpackage

//--- rtl/pin_sync_if.sv
`timescale 1ns/100ps
interface pin_sync_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_n_lvl;
  logic sel_n_fall;
  logic mosi_lvl;
  logic miso_lvl;
  modport producer (output sclk_rise, sclk_fall, sel_n_lvl, sel_n_fall, mosi_lvl, miso_lvl);
  modport consumer (input sclk_rise, sclk_fall, sel_n_lvl, sel_n_fall, mosi_lvl, miso_lvl);
endinterface

//--- rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
  import spi_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [PIN_COUNT-1:0] pins,
  pin_sync_if.producer sync
);

  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] lvl_q;
  logic [PIN_COUNT-1:0] old_q;

  // Two flops per pin; the third stage only feeds the edge detectors.
  // The select stages reset to its idle high level, so no false fall follows reset.
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta_q[g] <= (g == PIN_SEL_N);
        lvl_q[g] <= (g == PIN_SEL_N);
        old_q[g] <= (g == PIN_SEL_N);
      end else begin
        meta_q[g] <= pins[g];
        lvl_q[g] <= meta_q[g];
        old_q[g] <= lvl_q[g];
      end
    end
  end

  // Edges are seen one to two cycles after the pin moves.
  assign sync.sclk_rise = lvl_q[PIN_SCLK] & ~old_q[PIN_SCLK];
  assign sync.sclk_fall = ~lvl_q[PIN_SCLK] & old_q[PIN_SCLK];
  assign sync.sel_n_lvl = lvl_q[PIN_SEL_N];
  assign sync.sel_n_fall = ~lvl_q[PIN_SEL_N] & old_q[PIN_SEL_N];
  assign sync.mosi_lvl = lvl_q[PIN_MOSI];
  assign sync.miso_lvl = lvl_q[PIN_MISO];

endmodule

//--- test/spi_peer_model.sv
`timescale 1ns/100ps
module spi_peer_model (
  input wire logic active,
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic lsb,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int out_i;
  int in_i;

  function automatic int pos(input int k);
    return lsb ? k : 7 - k;
  endfunction

  // The line starts low and no byte has been received yet.
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
  end

  // Selection loads the byte; phase 0 needs its first bit before any clock edge.
  always @(negedge sel_n) begin
    if (active) begin
      out_i = 0;
      in_i = 0;
      if (!clock_phase) miso = tx_byte[pos(0)];
    end
  end

  // A leading edge leaves the idle level; phase decides which edge samples and which shifts.
  always @(sck) begin
    if (active && !sel_n) begin
      if ((sck !== clock_polarity) == !clock_phase) begin
        if (in_i < 8) rx_byte[pos(in_i)] = mosi;
        in_i++;
      end else if (!clock_phase) begin
        out_i++;
        if (out_i < 8) miso = tx_byte[pos(out_i)];
      end else begin
        if (out_i < 8) miso = tx_byte[pos(out_i)];
        out_i++;
      end
    end
  end

  // The line has no pull, so once released it shows the opposite of the last bit.
  always @(posedge sel_n) miso = ~miso;
endmodule

//--- test/spi_pin_control_and_config_tb.sv
`timescale 1ns/100ps
module spi_pin_control_and_config_tb
  import spi_cfg_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dps, chs, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe;
  logic tb_sck, tb_mosi, tb_sel, peer_on, peer_miso, clock_polarity_m, clock_phase_m, lsb_m;
  logic [7:0] peer_tx, peer_rx;
  logic [7:0] model [logic [7:0]];
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int edges = 0;
  // Each pin level is resolved from whoever enables a driver on it.
  wire sck_w = sck_oe ? sck_o : tb_sck;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : peer_miso;
  wire sel_w = sel_oe ? sel_o : tb_sel;

  spi_pin_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .deep_power_down(dps), .clock_halt_stop(chs),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_o), .miso_oe(miso_oe),
    .select_n_in(sel_w), .select_n_out(sel_o), .select_n_oe(sel_oe), .irq(irq)
  );

  spi_peer_model peer (
    .active(peer_on), .sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .clock_polarity(clock_polarity_m),
    .clock_phase(clock_phase_m), .lsb(lsb_m), .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx)
  );

  // The bus clock runs at 10 MHz.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Serial clock edges are counted so a transfer can be checked for its full length.
  always @(sck_o) edges++;

  // A hung handshake would stall forever, so a cycle ceiling ends the run.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (!chs && (a == ADDR_CTRL1 || a == ADDR_CTRL2 || a == ADDR_BAUD))
      model[a] = d & (a == ADDR_CTRL2 ? CTRL2_MASK : a == ADDR_BAUD ? BAUD_MASK : 8'hFF);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h00_0000, e});
  endtask

  // Disabling and changing phase in one write is unsafe, so the disable keeps the old phase.
  task automatic cfg(input logic [7:0] c1);
    wr(ADDR_CTRL1, {c1[7], 1'b0, c1[5:3], model[ADDR_CTRL1][2], c1[1:0]});
    wr(ADDR_CTRL1, c1);
  endtask

  task automatic xm(input logic [2:0] f, input logic [1:0] ie);
    logic [7:0] tx;
    int n;
    tx = 8'($urandom);
    peer_tx <= 8'($urandom);
    {clock_polarity_m, clock_phase_m, lsb_m} <= f;
    peer_on <= 1'b1;
    wr(ADDR_CTRL2, 8'h10);
    cfg({ie[1], 1'b1, ie[0], 1'b1, f[2], f[1], 1'b1, f[0]});
    // A polarity change reaches the clock pin a cycle after the write; skip that edge.
    repeat (2) @(posedge hclk);
    edges = 0;
    wr(ADDR_DATA, tx);
    n = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 8'h00);
      n++;
    end while (rd[S_RX_FULL] !== 1'b1 && n < 300);
    // The last clock edge and the select release can trail the receive flag by a half bit.
    repeat (12) @(posedge hclk);
    check(irq, ie[1] | ie[0]);
    check(edges, 16);
    check({sck_o, sel_o}, {f[2], 1'b1});
    rdc(ADDR_DATA, peer_tx);
    check(peer_rx, tx);
    rdc(ADDR_STATUS, 8'h20);
    check(irq, ie[0]);
  endtask

  // The bench acts as master here, on its own 800 ns clock off the bus clock's edges.
  task automatic xs(input logic [2:0] f);
    logic [7:0] dtx, mtx, got;
    int b;
    dtx = 8'($urandom);
    mtx = 8'($urandom);
    peer_on <= 1'b0;
    tb_sck <= f[2];
    wr(ADDR_CTRL2, 8'h00);
    cfg({4'h4, f[2], f[1], 1'b0, f[0]});
    wr(ADDR_DATA, dtx);
    #37 tb_sel = 1'b0;
    for (b = 0; b < 8; b++) begin
      if (!f[1]) begin
        tb_mosi = mtx[f[0] ? b : 7 - b];
        #(b == 0 ? 800 : 400);
        got[f[0] ? b : 7 - b] = miso_w;
        tb_sck = !f[2];
        #400 tb_sck = f[2];
      end else begin
        #400 tb_sck = !f[2];
        tb_mosi = mtx[f[0] ? b : 7 - b];
        #400 got[f[0] ? b : 7 - b] = miso_w;
        tb_sck = f[2];
      end
    end
    #400 tb_sel = 1'b1;
    repeat (5) @(posedge hclk);
    check(miso_oe, 1'b0);
    check(got, dtx);
    rdc(ADDR_DATA, mtx);
  endtask

  // Main sequence: reset, register map, pin roles, transfers, faults and stop modes.
  initial begin
    int i;
    logic [31:0] r;
    logic [3:0] e;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, dps, chs, tb_sck, tb_mosi, peer_on} = '0;
    {clock_polarity_m, clock_phase_m, lsb_m, peer_tx} = '0;
    tb_sel = 1'b1;
    hsize = 3'b010;
    model[ADDR_CTRL1] = 8'h00;
    model[ADDR_CTRL2] = 8'h00;
    model[ADDR_BAUD] = 8'h00;
    void'($urandom(32'h6a8f));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 6; i++) rdc(8'(i * 4), i == 3 ? 8'h20 : 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    wr(8'h14, 8'hFF);
    rdc(ADDR_STATUS, 8'h20);
    rdc(8'h14, 8'h00);
    for (i = 0; i < 128; i++) begin
      r = $urandom;
      wr(ADDR_CTRL2, {3'b000, i[4], i[3], 1'b0, r[4], i[2]});
      cfg({r[0], i[0], r[1], i[1], i[6], r[2], i[5], r[3]});
      repeat (4) @(posedge hclk);
      if (!i[0]) e = 4'h0;
      else if (i[1]) e = {1'b1, !i[2] | i[3], 1'b0, i[4] & i[5]};
      else e = {2'b00, i[2] & i[3], 1'b0};
      check({sck_oe, mosi_oe, miso_oe, sel_oe}, e);
      if (i[0] & i[1]) check(sck_o, i[6]);
      check(irq, r[1]);
      rdc(ADDR_CTRL1, model[ADDR_CTRL1]);
      rdc(ADDR_CTRL2, model[ADDR_CTRL2]);
    end
    wr(ADDR_BAUD, 8'h12);
    for (i = 0; i < 8; i++) xm(i[2:0], 2'($urandom));
    for (i = 0; i < 8; i++) xs(i[2:0]);
    // A low select while master with the fault input armed is a mode fault.
    wr(ADDR_CTRL2, 8'h10);
    cfg(8'hD0);
    tb_sel <= 1'b0;
    repeat (6) @(posedge hclk);
    tb_sel <= 1'b1;
    repeat (6) @(posedge hclk);
    check(irq, 1'b1);
    rdc(ADDR_STATUS, 8'h30);
    rdc(ADDR_CTRL1, 8'hC0);
    // Disabling in mid-byte aborts the transfer and restores the flags.
    wr(ADDR_BAUD, 8'h77);
    cfg(8'h50);
    wr(ADDR_DATA, 8'hA5);
    repeat (20) @(posedge hclk);
    wr(ADDR_CTRL1, 8'h10);
    rdc(ADDR_STATUS, 8'h20);
    check({sck_oe, mosi_oe, miso_oe, sel_oe}, 4'h0);
    cfg(8'h5C);
    dps <= 1'b1;
    repeat (3) @(posedge hclk);
    dps <= 1'b0;
    @(posedge hclk);
    foreach (model[k]) model[k] = 8'h00;
    rdc(ADDR_CTRL1, 8'h00);
    rdc(ADDR_BAUD, 8'h00);
    cfg(8'h50);
    chs <= 1'b1;
    repeat (4) @(posedge hclk);
    check({sck_oe, mosi_oe, miso_oe, sel_oe}, 4'h0);
    wr(ADDR_CTRL1, 8'h00);
    chs <= 1'b0;
    @(posedge hclk);
    rdc(ADDR_CTRL1, 8'h50);
    close_out();
  end
endmodule
